// ===== rtl/bl_prot_pkg.sv
// Constants and carrier types for the backlight protection and dimming block
package bl_prot_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned DEGLITCH_US = 2000;
  localparam int unsigned DEGLITCH_CYC = DEGLITCH_US * (CLK_HZ / 1_000_000);
  localparam logic [7:0] OFS_DRIVER_CONFIGURATION = 8'h02;
  localparam logic [7:0] OFS_BRIGHTNESS_LEVEL = 8'h04;
  localparam logic [7:0] OFS_FAULT_FLAGS = 8'h05;
  localparam int unsigned CFG_OVP_SEL_BIT = 7;
  localparam int unsigned CFG_DIM_EN_BIT = 6;
  localparam int unsigned CFG_DIM_POL_BIT = 5;
  localparam int unsigned CFG_FULL_SCALE_BIT = 3;
  localparam int unsigned CFG_STR1_EN_BIT = 2;
  localparam int unsigned CFG_STR2_EN_BIT = 1;
  localparam int unsigned CFG_DEV_EN_BIT = 0;
  localparam logic [7:0] CFG_RESET = 8'hC7;
  localparam logic [7:0] CFG_WRITE_MASK = 8'hEF;
  localparam logic [7:0] BRIGHT_RESET = 8'h00;
  localparam logic [7:0] BRIGHT_FULL = 8'hFF;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam int unsigned FLAG_STR1_BIT = 3;
  localparam int unsigned FLAG_STR2_BIT = 2;
  localparam int unsigned FLAG_OVP_BIT = 1;
  localparam int unsigned FLAG_OTP_BIT = 0;

  // Analog comparator results, all active high
  typedef struct packed {
    logic string_one_short;   // string_one_sink shorted or above 9.6 V
    logic string_two_short;   // string_two_sink shorted or above 9.6 V
    logic output_overvoltage; // Output at or above selected level
    logic over_temperature;   // Junction above 140 C
    logic supply_undervolt;   // Supply below lockout threshold
    logic supply_hyst_ok;     // Supply above threshold plus 200 mV
    logic switch_over_limit;  // Switch current above 1 A
  } sense_t;

  // Register access port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic boost_run;          // Boost converter may switch
    logic switch_gate;        // Power switch on (charging phase)
    logic overvoltage_level_select; // 0 low level, 1 high level
    logic full_scale_high;    // 0 small, 1 large full-scale
    logic [7:0] current_code; // Per-string current code, code/255 of FS
    logic string_one_on;
    logic string_two_on;
  } drive_t;
endpackage : bl_prot_pkg

// ===== rtl/backlight_protect_dim_ctrl.sv
// Protection, lockout and dimming control of a two-string backlight driver
//
// Overview of operation
// - Either string sink above 9.6 V counts as an LED-short event.
// - Short lasting over 2 ms latches shutdown; only enable pin clears it.
// - Over-temperature held continuously 2 ms latches shutdown.
// - After temperature latch, fresh power-on resumes switching automatically.
// - Configuration bit 7 selects the over-voltage threshold level.
// - Output reaching the over-voltage threshold shuts the driver down.
// - Supply undervoltage indication holds the device in shutdown.
// - Restart only once supply clears threshold plus hysteresis margin.
// - Switch current over limit holds the switch off while it lasts.
// - String current is brightness code over 255 times full scale.
// - Configuration bit 3 selects the full-scale current.
// - External pulse dims only when configuration bit 6 is one.
// - Over-voltage select: 0 lower threshold, 1 higher threshold.
// - Polarity bit: 0 pulse active high, 1 active low.
// - Short, over-voltage and temperature faults read as 1 flags.
`timescale 1ns/100ps
`default_nettype none
module backlight_protect_dim_ctrl
  import bl_prot_pkg::*;
#(
  parameter int unsigned DEGLITCH_CYCLES = DEGLITCH_CYC
) (
  input wire logic ref_clk_in,      // 100 MHz internal clock
  input wire logic rst_n_in,        // Enable pin, low resets
  input wire sense_t sense_in,      // Comparator results
  input wire logic dim_pulse_in,    // External dimming pulse
  input wire logic boost_pwm_in,    // Boost oscillator charge request
  input wire reg_req_t reg_req_in,  // Register access from serial slave
  output logic [7:0] reg_rdata_out, // Registered read data
  output drive_t drive_out,         // Drive to analog section
  output logic [3:0] fault_flags_out // Fault flag register image
);
  typedef enum {ST_LOCKOUT, ST_RUN, ST_LATCHED} pstate_t;
  localparam int unsigned NUM_TIMED = 2;
  localparam int unsigned TIMED_SHORT = 0;
  localparam int unsigned TIMED_TEMP = 1;

  // Register file
  logic [7:0] cfg_q;
  logic [7:0] cfg_d;
  logic [7:0] bright_q;
  logic [7:0] bright_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // Deglitch timers, one per timed fault
  logic [NUM_TIMED-1:0] timed_raw;
  logic [NUM_TIMED-1:0] timed_expired;
  logic [31:0] timed_cnt_q [NUM_TIMED];
  logic [31:0] timed_cnt_d [NUM_TIMED];

  // Protection state
  logic [3:0] flag_q;
  logic [3:0] flag_d;
  pstate_t st_q;
  pstate_t st_d;

  // Drive path
  logic gate_q;
  logic gate_d;
  logic dim_on;
  logic run_en;
  logic [7:0] code_q;
  logic [7:0] code_d;
  logic short_now;

  // sense bits already include the 9.6 V imbalance comparators
  assign short_now = sense_in.string_one_short | sense_in.string_two_short;

  // Short and temperature share one timer design; saturating at the
  // deglitch count keeps a long fault from wrapping back to zero
  assign timed_raw[TIMED_SHORT] = short_now;
  assign timed_raw[TIMED_TEMP] = sense_in.over_temperature;

  for (genvar g = 0; g < NUM_TIMED; g++) begin : g_timer
    always_comb begin
      timed_cnt_d[g] = timed_cnt_q[g];
      if (!timed_raw[g]) begin
        timed_cnt_d[g] = 32'h0;
      end else if (timed_cnt_q[g] < DEGLITCH_CYCLES) begin
        timed_cnt_d[g] = timed_cnt_q[g] + 32'h1;
      end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        timed_cnt_q[g] <= 32'h0;
      end else begin
        timed_cnt_q[g] <= timed_cnt_d[g];
      end
    end

    // Fault held past the deglitch time and still present
    assign timed_expired[g] = timed_raw[g] &&
      timed_cnt_q[g] >= DEGLITCH_CYCLES;
  end

  // Register file; reserved config bit is forced to zero on write
  // Reads return data one cycle after the strobe
  always_comb begin
    cfg_d = cfg_q;
    bright_d = bright_q;
    rdata_d = rdata_q;
    if (reg_req_in.wr && reg_req_in.addr == OFS_DRIVER_CONFIGURATION) begin
      cfg_d = reg_req_in.wdata & CFG_WRITE_MASK;
    end
    if (reg_req_in.wr && reg_req_in.addr == OFS_BRIGHTNESS_LEVEL) begin
      bright_d = reg_req_in.wdata;
    end
    if (reg_req_in.rd) begin
      case (reg_req_in.addr)
        OFS_DRIVER_CONFIGURATION: rdata_d = cfg_q;
        OFS_BRIGHTNESS_LEVEL: rdata_d = bright_q;
        OFS_FAULT_FLAGS: rdata_d = {4'h0, flag_q};
        default: rdata_d = READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_q <= CFG_RESET;
      bright_q <= BRIGHT_RESET;
      rdata_q <= READ_ZERO;
    end else begin
      cfg_q <= cfg_d;
      bright_q <= bright_d;
      rdata_q <= rdata_d;
    end
  end

  // Protection state
  always_comb begin
    st_d = st_q;
    flag_d = flag_q;
    case (st_q)
      ST_LOCKOUT: begin
        // Hysteresis comparator must clear, not just the lockout one
        if (!sense_in.supply_undervolt && sense_in.supply_hyst_ok) begin
          st_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (sense_in.supply_undervolt) begin
          st_d = ST_LOCKOUT;
        end
        if (timed_expired[TIMED_SHORT]) begin
          st_d = ST_LATCHED;
          flag_d[FLAG_STR1_BIT] = sense_in.string_one_short;
          flag_d[FLAG_STR2_BIT] = sense_in.string_two_short;
        end
        if (timed_expired[TIMED_TEMP]) begin
          st_d = ST_LATCHED;
          flag_d[FLAG_OTP_BIT] = 1'b1;
        end
        // Over-voltage needs no deglitch, it latches at once
        if (sense_in.output_overvoltage) begin
          st_d = ST_LATCHED;
          flag_d[FLAG_OVP_BIT] = 1'b1;
        end
      end
      // Flags stay as latched; a later fault adds nothing
      ST_LATCHED: st_d = ST_LATCHED; // Only the enable pin leaves here
      default: st_d = ST_LOCKOUT;
    endcase
  end

  // Enable pin reset returns everything to lockout
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= ST_LOCKOUT;
      flag_q <= 4'h0;
    end else begin
      st_q <= st_d;
      flag_q <= flag_d;
    end
  end

  // Run only while protection allows it and software has the device on
  assign run_en = (st_q == ST_RUN) && cfg_q[CFG_DEV_EN_BIT];

  // Switching and current drive
  always_comb begin
    dim_on = !cfg_q[CFG_DIM_EN_BIT] ||
             (dim_pulse_in ^ cfg_q[CFG_DIM_POL_BIT]);
    // current limit overrides the oscillator mid-cycle
    gate_d = run_en && boost_pwm_in &&
             !sense_in.switch_over_limit && !sense_in.output_overvoltage;
    code_d = (run_en && dim_on) ? bright_q : 8'h00;
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gate_q <= 1'b0;
      code_q <= 8'h00;
    end else begin
      gate_q <= gate_d;
      code_q <= code_d;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign fault_flags_out = flag_q;
  always_comb begin
    drive_out.boost_run = run_en;
    drive_out.switch_gate = gate_q;
    // Mode bits go straight to the analog section
    drive_out.overvoltage_level_select = cfg_q[CFG_OVP_SEL_BIT];
    drive_out.full_scale_high = cfg_q[CFG_FULL_SCALE_BIT];
    drive_out.current_code = code_q;
    drive_out.string_one_on = cfg_q[CFG_STR1_EN_BIT];
    drive_out.string_two_on = cfg_q[CFG_STR2_EN_BIT];
  end
endmodule : backlight_protect_dim_ctrl
`default_nettype wire

// ===== testbench/bl_prot_properties.sv
// Timing checker for the backlight protection and drive outputs
`timescale 1ns/100ps
`default_nettype none
module bl_prot_properties
  import bl_prot_pkg::*;
#(
  parameter int unsigned DEGLITCH_CYCLES = 20
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire sense_t sense_in,
  input wire drive_t drive_out,
  input wire logic [3:0] fault_flags_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Consecutive short samples, to bound when the latch may fire
  logic [31:0] held_q;
  logic [31:0] held_d;
  always_comb held_d = sense_in.string_one_short ? held_q + 32'h1 : 32'h0;
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) held_q <= 32'h0;
    else held_q <= held_d;
  end
  property p_lim; sense_in.switch_over_limit |=> !drive_out.switch_gate;
  endproperty
  a_lim: assert property (p_lim) else $error("gate on over limit");
  property p_ovp; sense_in.output_overvoltage |=> !drive_out.switch_gate;
  endproperty
  a_ovp: assert property (p_ovp) else $error("gate on overvoltage");
  property p_uv; sense_in.supply_undervolt |=> !drive_out.boost_run;
  endproperty
  a_uv: assert property (p_uv) else $error("run in undervolt");
  property p_hyst;
    !drive_out.boost_run && !sense_in.supply_hyst_ok |=> !drive_out.boost_run;
  endproperty
  a_hyst: assert property (p_hyst) else $error("early restart");
  property p_short;
    $rose(fault_flags_out[3]) |-> held_q > DEGLITCH_CYCLES;
  endproperty
  a_short: assert property (p_short) else $error("short too early");
  property p_flag_ovp;
    $rose(fault_flags_out[1]) |-> $past(sense_in.output_overvoltage) ||
      $past(sense_in.output_overvoltage, 2);
  endproperty
  a_flag_ovp: assert property (p_flag_ovp) else $error("stray ovp");
  property p_latch; |fault_flags_out |-> !drive_out.boost_run; endproperty
  a_latch: assert property (p_latch) else $error("run latched");
  property p_hold;
    |fault_flags_out |=> (fault_flags_out & $past(fault_flags_out)) ==
      $past(fault_flags_out);
  endproperty
  a_hold: assert property (p_hold) else $error("latch cleared");
  property p_code; !drive_out.boost_run |=> drive_out.current_code == 8'h00;
  endproperty
  a_code: assert property (p_code) else $error("current off run");
  c_short: cover property ($rose(fault_flags_out[3]));
  c_temp: cover property ($rose(fault_flags_out[0]));
  c_ovp: cover property ($rose(fault_flags_out[1]));
endmodule : bl_prot_properties
`default_nettype wire

// ===== testbench/host_model.sv
// Host side model: register strobes and dimming pulse source
`timescale 1ns/100ps
`default_nettype none
module host_model
  import bl_prot_pkg::*;
#(
  parameter int HALF_CYC = 2500
) (
  input wire logic clk_in,  // Block clock
  output reg_req_t req_out, // Register strobes
  output logic dim_out      // Dimming pulse
);
  int cnt = 0;
  initial begin
    req_out = '0;
    dim_out = 1'b0;
  end
  always @(negedge clk_in) begin
    cnt = (cnt + 1) % HALF_CYC;
    if (cnt == 0) dim_out = !dim_out;
  end
  task automatic access(input logic w, input logic [7:0] a,
                        input logic [7:0] d);
    @(negedge clk_in);
    req_out = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge clk_in);
    req_out = '0;
  endtask : access
endmodule : host_model
`default_nettype wire

// ===== testbench/tb.sv
// Self-checking bench of the backlight protection and dimming block
`timescale 1ns/100ps
`default_nettype none
module tb;
  import bl_prot_pkg::*;
  localparam int unsigned D = 20;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic pwm = 1'b0;
  logic dim;
  sense_t sense = '0;
  reg_req_t req;
  logic [7:0] rdata;
  drive_t drv;
  logic [3:0] flags;
  logic [7:0] expq[$];
  logic [7:0] v;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  int sb[4] = '{6, 5, 3, 4};
  int fb[4] = '{3, 2, 0, 1};
  always #5 ref_clk_in = !ref_clk_in;
  host_model #(.HALF_CYC(2500)) host (.clk_in(ref_clk_in), .req_out(req),
    .dim_out(dim));
  backlight_protect_dim_ctrl #(.DEGLITCH_CYCLES(D)) uut (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .sense_in(sense),
    .dim_pulse_in(dim), .boost_pwm_in(pwm), .reg_req_in(req),
    .reg_rdata_out(rdata), .drive_out(drv), .fault_flags_out(flags));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expq.push_back(e);
    host.access(1'b0, a, 8'h00);
  endtask : rd
  task automatic conclude;
    if (error_cnt == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude
  always @(posedge ref_clk_in) if (req.rd) begin
    #1 check(rdata, expq.pop_front());
  end
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      conclude();
    end
  end
  // Oscillator and limit comparator stay busy to exercise the gate
  always @(negedge ref_clk_in) begin
    pwm = 1'($urandom);
    sense.switch_over_limit = ($urandom % 4) == 0;
  end
  initial begin
    v = 8'($urandom(81));
    sense.supply_hyst_ok = 1'b1;
    repeat (16) @(negedge ref_clk_in);
    rst_n_in = 1'b1;
    rd(OFS_DRIVER_CONFIGURATION, CFG_RESET);
    rd(OFS_BRIGHTNESS_LEVEL, BRIGHT_RESET);
    rd(8'h00, READ_ZERO);
    host.access(1'b1, OFS_FAULT_FLAGS, 8'hFF);
    rd(OFS_FAULT_FLAGS, READ_ZERO);
    repeat (3) begin
      v = 8'($urandom) | 8'h01;
      host.access(1'b1, OFS_DRIVER_CONFIGURATION, v);
      rd(OFS_DRIVER_CONFIGURATION, v & CFG_WRITE_MASK);
      check({7'h00, drv.overvoltage_level_select}, {7'h00, v[7]});
      check({7'h00, drv.full_scale_high}, {7'h00, v[3]});
      check({6'h00, drv.string_one_on, drv.string_two_on},
        {6'h00, v[2], v[1]});
    end
    v = 8'($urandom);
    host.access(1'b1, OFS_BRIGHTNESS_LEVEL, v);
    for (int m = 0; m < 3; m++) begin
      host.access(1'b1, OFS_DRIVER_CONFIGURATION,
        m == 0 ? 8'h87 : (m == 1 ? 8'hC7 : 8'hE7));
      repeat (60) begin
        repeat (100) @(posedge ref_clk_in);
        #1 check(drv.current_code, (m == 0 || (dim ^ (m == 2))) ? v : 8'h00);
      end
    end
    @(negedge ref_clk_in);
    sense.supply_undervolt = 1'b1;
    sense.supply_hyst_ok = 1'b0;
    repeat (5) @(negedge ref_clk_in);
    check({7'h00, drv.boost_run}, 8'h00);
    sense.supply_undervolt = 1'b0;
    repeat (5) @(negedge ref_clk_in);
    check({7'h00, drv.boost_run}, 8'h00);
    sense.supply_hyst_ok = 1'b1;
    repeat (3) @(negedge ref_clk_in);
    check({7'h00, drv.boost_run}, 8'h01);
    for (int i = 0; i < 4; i++) begin
      sense[sb[i]] = 1'b1;
      repeat (D) @(negedge ref_clk_in);
      sense[sb[i]] = 1'b0;
      repeat (2) @(negedge ref_clk_in);
      if (i < 3) check({4'h0, flags}, 8'h00);
      sense[sb[i]] = 1'b1;
      repeat (D + 3) @(negedge ref_clk_in);
      sense[sb[i]] = 1'b0;
      repeat (3) @(negedge ref_clk_in);
      check({4'h0, flags}, 8'h01 << fb[i]);
      rd(OFS_FAULT_FLAGS, 8'h01 << fb[i]);
      check({7'h00, drv.boost_run}, 8'h00);
      rst_n_in = 1'b0;
      @(negedge ref_clk_in);
      rst_n_in = 1'b1;
      repeat (3) @(negedge ref_clk_in);
      check({3'h0, flags, drv.boost_run}, 8'h01);
    end
    conclude();
  end
endmodule : tb
bind backlight_protect_dim_ctrl bl_prot_properties #(
  .DEGLITCH_CYCLES(DEGLITCH_CYCLES)) props (.ref_clk_in(ref_clk_in),
  .rst_n_in(rst_n_in), .sense_in(sense_in), .drive_out(drive_out),
  .fault_flags_out(fault_flags_out));
`default_nettype wire
